// ### verilog/pio_pkg.sv
package pio_pkg;

  // Geometry of the pin array
  localparam int PIO_PORTS = 11;
  localparam int PIO_PINS = 88;
  localparam int PIO_GROUPS = 22;
  localparam int PIO_USABLE_PINS = 87;
  localparam int PIO_NMI_PORT = 8;
  localparam int PIO_NMI_BIT = 5;
  localparam int PIO_NMI_PIN = 69;

  // Address layout: bank in paddr[9:6], port index in paddr[5:2]
  localparam logic [11:0] PIO_DIR_BASE = 12'h000;
  localparam logic [11:0] PIO_DATA_BASE = 12'h040;
  localparam logic [11:0] PIO_SELA_BASE = 12'h080;
  localparam logic [11:0] PIO_SELB_BASE = 12'h0C0;
  localparam logic [11:0] PIO_SELC_BASE = 12'h100;
  localparam logic [11:0] PIO_SELD_BASE = 12'h140;
  localparam logic [11:0] PIO_PULL_ADDR = 12'h180;
  localparam int PIO_BANK_LSB = 6;
  localparam int PIO_IDX_LSB = 2;

  // Reset values
  localparam logic [87:0] PIO_VEC_RST = 88'h0;
  localparam logic [21:0] PIO_PULL_RST = 22'h0;
  localparam logic [7:0] PIO_NMI_PORT_MASK = 8'hDF;
  localparam logic [7:0] PIO_FULL_PORT_MASK = 8'hFF;
  localparam logic [87:0] PIO_IMPL_PINS = ~(88'h1 << PIO_NMI_PIN);

  // Register banks, in address order
  typedef enum logic [3:0] {
    PIO_BANK_DIR, PIO_BANK_DATA, PIO_BANK_SELA, PIO_BANK_SELB,
    PIO_BANK_SELC, PIO_BANK_SELD, PIO_BANK_PULL
  } pio_bank_t;

  // Writable bits of one port
  function automatic logic [7:0] pio_impl_mask(input int p);
    return (p == PIO_NMI_PORT) ? PIO_NMI_PORT_MASK : PIO_FULL_PORT_MASK;
  endfunction

  // Replace one port lane of a pin vector
  function automatic logic [87:0] pio_lane_write(input logic [87:0] old,
      input logic [3:0] idx, input logic [7:0] val);
    logic [87:0] res;
    res = old;
    for (int p = 0; p < PIO_PORTS; p++) begin
      if (idx == 4'(p)) res[8*p +: 8] = val & pio_impl_mask(p);
    end
    return res;
  endfunction

  // Pick one port lane of a pin vector
  function automatic logic [7:0] pio_lane_read(input logic [87:0] vec,
      input logic [3:0] idx);
    logic [7:0] res;
    res = 8'h00;
    for (int p = 0; p < PIO_PORTS; p++) begin
      if (idx == 4'(p)) res = vec[8*p +: 8];
    end
    return res;
  endfunction

endpackage

// ### verilog/pio_apb_decode.sv
`timescale 1ns/10ps
module pio_apb_decode import pio_pkg::*; (
  input wire logic [11:0] paddr,
  output pio_bank_t bank,
  output logic [3:0] idx,
  output logic hit
);

  // Split the word address into bank and lane
  wire [3:0] bank_raw = paddr[PIO_BANK_LSB +: 4];
  wire aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  wire lane_ok = (idx < 4'(PIO_PORTS));
  wire pull_ok = (paddr == PIO_PULL_ADDR);

  assign idx = paddr[PIO_IDX_LSB +: 4];
  assign bank = pio_bank_t'(bank_raw);
  // Port banks take 11 lanes, pull-up bank a single word
  assign hit = aligned && (pull_ok || ((bank_raw < 4'(PIO_BANK_PULL)) && lane_ok));

endmodule // pio_apb_decode

// ### verilog/pio_pin_mux.sv
`timescale 1ns/10ps
module pio_pin_mux import pio_pkg::*; (
  input wire logic bus_mode,
  input wire logic [87:0] bus_pin_mask,
  input wire logic [87:0] bus_out,
  input wire logic [87:0] bus_oe,
  input wire logic [87:0] dir,
  input wire logic [87:0] data,
  input wire logic [87:0] sel_a,
  input wire logic [87:0] sel_b,
  input wire logic [87:0] sel_c,
  input wire logic [87:0] sel_d,
  input wire logic [87:0] periph_out0,
  input wire logic [87:0] periph_out1,
  input wire logic [87:0] periph_out2,
  input wire logic [87:0] periph_out3,
  input wire logic [21:0] pull_grp,
  output logic [87:0] drv_val,
  output logic [87:0] drv_oe_n,
  output logic [87:0] pull_en
);

  logic [87:0] pull_flat;
  // Spread each group bit over its four pins
  for (genvar k = 0; k < PIO_PINS; k++) begin : g_pull
    assign pull_flat[k] = pull_grp[k / 4];
  end

  // One role per pin: bus, then peripheral, then port
  wire [87:0] bus_own = {88{bus_mode}} & bus_pin_mask & PIO_IMPL_PINS;
  wire [87:0] per_own = ~bus_own & sel_a & PIO_IMPL_PINS;
  wire [87:0] port_own = ~bus_own & ~sel_a & dir & PIO_IMPL_PINS;
  wire [87:0] per_low = (sel_c & periph_out2) | (~sel_c & periph_out0);
  wire [87:0] per_mid = (sel_b & periph_out1) | (~sel_b & per_low);
  wire [87:0] per_val = (sel_d & periph_out3) | (~sel_d & per_mid);
  wire [87:0] drive = (bus_own & bus_oe) | per_own | port_own;

  assign drv_val = (bus_own & bus_out) | (per_own & per_val) | (port_own & data);
  assign drv_oe_n = ~drive;
  // Pull-up only on undriven input pins, never on the interrupt pin
  assign pull_en = pull_flat & ~dir & ~drive & ~bus_own & PIO_IMPL_PINS;

endmodule // pio_pin_mux

// ### verilog/pio_top.sv
// Overview of operation
// - 87 usable pins over eleven ports
// - Direction bit per pin, one register per port
// - Interrupt-shared pin input only, never pulled up
// - Port 8 data bit 5 reads interrupt level
// - No direction bit exists for interrupt pin
// - Bus-owned pins ignore direction and data registers
// - Data write loads latch, read samples pins
// - Primary select picks port or peripheral output
// - Secondary selects pick among several peripheral outputs
// - One pull-up bit per four pins
// - Pull-up only when bit set and input
// - Ports 0, 1, P4 low still pullable as inputs
// - Each pin has exactly one role
`timescale 1ns/10ps
module pio_top import pio_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_mode,
  input wire logic [87:0] bus_pin_mask,
  input wire logic [87:0] bus_out,
  input wire logic [87:0] bus_oe,
  input wire logic [87:0] periph_out0,
  input wire logic [87:0] periph_out1,
  input wire logic [87:0] periph_out2,
  input wire logic [87:0] periph_out3,
  input wire logic [87:0] pin_in,
  output logic [87:0] pin_out,
  output logic [87:0] pin_oe_n,
  output logic [87:0] pin_pullup,
  output logic nmi_level
);

  // Register state
  logic [87:0] dir_r, dir_nxt;
  logic [87:0] data_r, data_nxt;
  logic [87:0] sela_r, sela_nxt;
  logic [87:0] selb_r, selb_nxt;
  logic [87:0] selc_r, selc_nxt;
  logic [87:0] seld_r, seld_nxt;
  logic [21:0] pull_r, pull_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r;
  logic pslverr_r, pslverr_nxt;
  logic [87:0] pin_out_r, pin_oe_n_r, pin_pullup_r;
  logic nmi_level_r;

  pio_bank_t bank;
  logic [3:0] idx;
  logic hit;
  logic [87:0] drv_val, drv_oe_n, pull_en;

  // Address decode
  pio_apb_decode u_decode (
    .paddr(paddr),
    .bank(bank),
    .idx(idx),
    .hit(hit)
  );

  // APB phases
  wire setup_ph = psel && !penable;
  wire wr_acc = psel && penable && pready_r && pwrite && hit;
  wire [7:0] wbyte = pwdata[7:0];
  wire wr_dir = wr_acc && (bank == PIO_BANK_DIR);
  wire wr_data = wr_acc && (bank == PIO_BANK_DATA);
  wire wr_sela = wr_acc && (bank == PIO_BANK_SELA);
  wire wr_selb = wr_acc && (bank == PIO_BANK_SELB);
  wire wr_selc = wr_acc && (bank == PIO_BANK_SELC);
  wire wr_seld = wr_acc && (bank == PIO_BANK_SELD);
  wire wr_pull = wr_acc && (bank == PIO_BANK_PULL);

  // Register next values; interrupt pin bit of its lane is masked off
  assign dir_nxt = wr_dir ? pio_lane_write(dir_r, idx, wbyte) : dir_r;
  assign data_nxt = wr_data ? pio_lane_write(data_r, idx, wbyte) : data_r;
  assign sela_nxt = wr_sela ? pio_lane_write(sela_r, idx, wbyte) : sela_r;
  assign selb_nxt = wr_selb ? pio_lane_write(selb_r, idx, wbyte) : selb_r;
  assign selc_nxt = wr_selc ? pio_lane_write(selc_r, idx, wbyte) : selc_r;
  assign seld_nxt = wr_seld ? pio_lane_write(seld_r, idx, wbyte) : seld_r;
  assign pull_nxt = wr_pull ? pwdata[21:0] : pull_r;

  // Port data read shows live pins, interrupt level included
  wire [7:0] pin_lane = pio_lane_read(pin_in, idx);
  wire [7:0] rd_byte = (bank == PIO_BANK_DIR) ? pio_lane_read(dir_r, idx) :
                       (bank == PIO_BANK_DATA) ? pin_lane :
                       (bank == PIO_BANK_SELA) ? pio_lane_read(sela_r, idx) :
                       (bank == PIO_BANK_SELB) ? pio_lane_read(selb_r, idx) :
                       (bank == PIO_BANK_SELC) ? pio_lane_read(selc_r, idx) :
                       pio_lane_read(seld_r, idx);
  wire [31:0] rd_word = (bank == PIO_BANK_PULL) ? {10'h000, pull_r} : {24'h000000, rd_byte};

  // Read data and error captured in the setup cycle
  assign prdata_nxt = (setup_ph && !pwrite && hit) ? rd_word :
                      setup_ph ? 32'h00000000 : prdata_r;
  assign pslverr_nxt = setup_ph ? !hit : pslverr_r;

  // Pin role selection and pull-up gating
  pio_pin_mux u_mux (
    .bus_mode(bus_mode),
    .bus_pin_mask(bus_pin_mask),
    .bus_out(bus_out),
    .bus_oe(bus_oe),
    .dir(dir_r),
    .data(data_r),
    .sel_a(sela_r),
    .sel_b(selb_r),
    .sel_c(selc_r),
    .sel_d(seld_r),
    .periph_out0(periph_out0),
    .periph_out1(periph_out1),
    .periph_out2(periph_out2),
    .periph_out3(periph_out3),
    .pull_grp(pull_r),
    .drv_val(drv_val),
    .drv_oe_n(drv_oe_n),
    .pull_en(pull_en)
  );

  // Configuration registers; reset leaves every pin an input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_r <= PIO_VEC_RST;
      data_r <= PIO_VEC_RST;
      sela_r <= PIO_VEC_RST;
      selb_r <= PIO_VEC_RST;
      selc_r <= PIO_VEC_RST;
      seld_r <= PIO_VEC_RST;
      pull_r <= PIO_PULL_RST;
    end else begin
      dir_r <= dir_nxt;
      data_r <= data_nxt;
      sela_r <= sela_nxt;
      selb_r <= selb_nxt;
      selc_r <= selc_nxt;
      seld_r <= seld_nxt;
      pull_r <= pull_nxt;
    end
  end

  // Bus answer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= 1'b1;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Pin drive flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_r <= PIO_VEC_RST;
      pin_oe_n_r <= ~PIO_VEC_RST;
      pin_pullup_r <= PIO_VEC_RST;
      nmi_level_r <= 1'b0;
    end else begin
      pin_out_r <= drv_val;
      pin_oe_n_r <= drv_oe_n;
      pin_pullup_r <= pull_en;
      nmi_level_r <= pin_in[PIO_NMI_PIN];
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pin_out = pin_out_r;
  assign pin_oe_n = pin_oe_n_r;
  assign pin_pullup = pin_pullup_r;
  assign nmi_level = nmi_level_r;

  // Helper views for the checks below
  wire [87:0] drivable = dir_r | sela_r;
  wire [87:0] bus_pins = bus_pin_mask & PIO_IMPL_PINS;
  wire port0_port = !bus_mode && !sela_r[0] && dir_r[0];
  wire port0_per = !bus_mode && sela_r[0] && !selb_r[0] && !selc_r[0] && !seld_r[0];
  wire pin1_pull_case = pull_r[0] && !dir_r[1] && !sela_r[1] && !bus_mode;
  wire nmi_rd_setup = setup_ph && !pwrite && hit && (bank == PIO_BANK_DATA) &&
                      (idx == 4'(PIO_NMI_PORT));

  // Setup followed by a zero-wait access
  sequence s_setup_rd_data;
    setup_ph && !pwrite && hit && (bank == PIO_BANK_DATA);
  endsequence

  sequence s_access;
    psel && penable && pready;
  endsequence

  property p_nmi_never_driven;
    @(posedge pclk) disable iff (!presetn)
      pin_oe_n[PIO_NMI_PIN] && !pin_pullup[PIO_NMI_PIN];
  endproperty
  a_nmi_never_driven: assert property (p_nmi_never_driven)
    else $error("interrupt pin driven or pulled up");

  property p_no_nmi_dir_bit;
    @(posedge pclk) disable iff (!presetn)
      !dir_r[PIO_NMI_PIN] && !sela_r[PIO_NMI_PIN];
  endproperty
  a_no_nmi_dir_bit: assert property (p_no_nmi_dir_bit)
    else $error("direction bit exists for interrupt pin");

  property p_nmi_read;
    @(posedge pclk) disable iff (!presetn)
      nmi_rd_setup |=> (prdata[PIO_NMI_BIT] == $past(pin_in[PIO_NMI_PIN]));
  endproperty
  a_nmi_read: assert property (p_nmi_read)
    else $error("port 8 bit 5 does not show interrupt level");

  property p_data_read_pins;
    @(posedge pclk) disable iff (!presetn)
      s_setup_rd_data ##1 s_access |-> (prdata[7:0] == $past(pin_lane));
  endproperty
  a_data_read_pins: assert property (p_data_read_pins)
    else $error("data read does not return pin states");

  property p_port_drive;
    @(posedge pclk) disable iff (!presetn)
      port0_port |=> (!pin_oe_n[0] && pin_out[0] == $past(data_r[0]));
  endproperty
  a_port_drive: assert property (p_port_drive)
    else $error("output latch not driven on port pin");

  property p_periph_drive;
    @(posedge pclk) disable iff (!presetn)
      port0_per |=> (!pin_oe_n[0] && pin_out[0] == $past(periph_out0[0]));
  endproperty
  a_periph_drive: assert property (p_periph_drive)
    else $error("primary select does not route peripheral");

  property p_periph_alt;
    @(posedge pclk) disable iff (!presetn)
      (!bus_mode && sela_r[0] && selb_r[0] && !seld_r[0]) |=>
        (pin_out[0] == $past(periph_out1[0]));
  endproperty
  a_periph_alt: assert property (p_periph_alt)
    else $error("secondary select does not pick peripheral");

  property p_bus_owns;
    @(posedge pclk) disable iff (!presetn)
      bus_mode |=>
        (((pin_out ^ $past(bus_out)) & $past(bus_pins)) == 88'h0) &&
        (((pin_oe_n ^ ~$past(bus_oe)) & $past(bus_pins)) == 88'h0);
  endproperty
  a_bus_owns: assert property (p_bus_owns)
    else $error("bus pin affected by port registers");

  property p_pull_group;
    @(posedge pclk) disable iff (!presetn)
      pin1_pull_case |=> pin_pullup[1];
  endproperty
  a_pull_group: assert property (p_pull_group)
    else $error("group pull-up missing on input pin");

  property p_pull_inputs_only;
    @(posedge pclk) disable iff (!presetn)
      ##1 ((pin_pullup & ~pin_oe_n) == 88'h0) && ((pin_pullup & $past(drivable)) == 88'h0);
  endproperty
  a_pull_inputs_only: assert property (p_pull_inputs_only)
    else $error("pull-up on an output pin");

  property p_reset_state;
    @(posedge pclk) $rose(presetn) |->
      (dir_r == 88'h0) && (sela_r == 88'h0) && (pull_r == 22'h0) && (&pin_oe_n);
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("reset state not all inputs");

  property p_pin_count;
    @(posedge pclk) disable iff (!presetn)
      $countones(~pin_oe_n) <= PIO_USABLE_PINS;
  endproperty
  a_pin_count: assert property (p_pin_count)
    else $error("usable pin count wrong");

  property p_dir_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_dir && idx == 4'h0) |=> (dir_r[7:0] == $past(wbyte));
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write not stored");

  property p_data_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_data && idx == 4'h0) |=> (data_r[7:0] == $past(wbyte));
  endproperty
  a_data_write: assert property (p_data_write)
    else $error("data latch write not stored");

  property p_sela_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_sela && idx == 4'h0) |=> (sela_r[7:0] == $past(wbyte));
  endproperty
  a_sela_write: assert property (p_sela_write)
    else $error("primary select write not stored");

  property p_pull_write;
    @(posedge pclk) disable iff (!presetn)
      wr_pull |=> (pull_r == $past(pwdata[21:0]));
  endproperty
  a_pull_write: assert property (p_pull_write)
    else $error("pull-up group write not stored");

  property p_port_input;
    @(posedge pclk) disable iff (!presetn)
      (!bus_mode && !sela_r[0] && !dir_r[0]) |=> pin_oe_n[0];
  endproperty
  a_port_input: assert property (p_port_input)
    else $error("input pin driven");

  property p_nmi_follow;
    @(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> (nmi_level == $past(pin_in[PIO_NMI_PIN]));
  endproperty
  a_nmi_follow: assert property (p_nmi_follow)
    else $error("interrupt level output does not follow pin");

  property p_bus_no_pull;
    @(posedge pclk) disable iff (!presetn)
      bus_mode |=> ((pin_pullup & $past(bus_pins)) == 88'h0);
  endproperty
  a_bus_no_pull: assert property (p_bus_no_pull)
    else $error("bus pin pulled up");

  property p_bus_mode_pull;
    @(posedge pclk) disable iff (!presetn)
      (bus_mode && !bus_pin_mask[0] && pull_r[0] && !dir_r[0] && !sela_r[0]) |=>
        pin_pullup[0];
  endproperty
  a_bus_mode_pull: assert property (p_bus_mode_pull)
    else $error("input port not pullable in bus mode");

  property p_slverr_map;
    @(posedge pclk) disable iff (!presetn)
      setup_ph |=> (pslverr == !$past(hit));
  endproperty
  a_slverr_map: assert property (p_slverr_map)
    else $error("error response does not match address map");

endmodule // pio_top

// ### verif/pio_ext_dev.sv
`timescale 1ns/10ps
module pio_ext_dev (
  input wire logic pclk,
  input wire logic [87:0] pin_out,
  input wire logic [87:0] pin_oe_n,
  input wire logic [87:0] pin_pullup,
  input wire logic [87:0] ext_val,
  input wire logic [87:0] ext_en,
  output logic [87:0] pin_in
);
  logic [87:0] last_r = '0;

  // Wire level: device drive, then outside drive, then pull-up, else drifting
  always_comb begin
    for (int k = 0; k < 88; k++) begin
      if (!pin_oe_n[k]) pin_in[k] = pin_out[k];
      else if (ext_en[k]) pin_in[k] = ext_val[k];
      else if (pin_pullup[k]) pin_in[k] = 1'b1;
      else pin_in[k] = ~last_r[k]; // Floating pin flips each cycle
    end
  end

  // Last level seen, for floating pins
  always_ff @(posedge pclk) begin
    last_r <= pin_in;
  end
endmodule // pio_ext_dev

// ### verif/programmable_io_port_block_bench.sv
`timescale 1ns/10ps
module programmable_io_port_block_bench import pio_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, bus_mode = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, nmi_level, er;
  logic [87:0] bus_pin_mask = '0, bus_out = '0, bus_oe = '0, ext_val = '0, ext_en = '0;
  logic [87:0] periph_out0 = {11{8'h11}}, periph_out1 = {11{8'h22}};
  logic [87:0] periph_out2 = {11{8'h44}}, periph_out3 = {11{8'h88}};
  logic [87:0] pin_in, pin_out, pin_oe_n, pin_pullup, exp;
  int err_total = 0, n_tests = 0, cyc = 0;

  // Device and the outside world
  pio_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_mode(bus_mode), .bus_pin_mask(bus_pin_mask),
    .bus_out(bus_out), .bus_oe(bus_oe), .periph_out0(periph_out0),
    .periph_out1(periph_out1), .periph_out2(periph_out2), .periph_out3(periph_out3),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup),
    .nmi_level(nmi_level));
  pio_ext_dev u_ext (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup(pin_pullup), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  // Clock
  initial begin
    forever #50 pclk = ~pclk;
  end

  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_of_test;
    end
  end

  task automatic chk(input string nm, input logic [87:0] e, input logic [87:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer, waiting on pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdr(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  function automatic logic [11:0] ra(input logic [11:0] b, input int p);
    return b + 12'(4 * p);
  endfunction

  task automatic settle;
    repeat (2) @(posedge pclk);
  endtask

  task automatic t_reset;
    for (int b = 0; b < 6; b++) begin
      for (int p = 0; p < PIO_PORTS; p++) begin
        if (b != 1) begin
          rdr(12'(64 * b + 4 * p));
          chk("config reg", 88'h0, 88'(rd));
        end
      end
    end
    rdr(PIO_PULL_ADDR);
    chk("pull reg", 88'h0, 88'(rd));
    rdr(12'h02C);
    chk("unmapped err", 88'h1, 88'(er));
    chk("oe_n", {88{1'b1}}, pin_oe_n);
    chk("pullup", 88'h0, pin_pullup);
    $display("test reset done");
  endtask

  task automatic t_dir;
    for (int p = 0; p < PIO_PORTS; p++) begin
      wr(ra(PIO_DIR_BASE, p), 32'hFF);
      wr(ra(PIO_DATA_BASE, p), 32'(8'h5A ^ 8'(p)));
      exp[8*p +: 8] = 8'h5A ^ 8'(p);
    end
    settle;
    chk("oe_n", 88'h1 << PIO_NMI_PIN, pin_oe_n);
    chk("out", exp & PIO_IMPL_PINS, pin_out & PIO_IMPL_PINS);
    chk("driven count", 88'h57, 88'($countones(~pin_oe_n)));
    rdr(ra(PIO_DIR_BASE, 8));
    chk("dir port 8", 88'hDF, 88'(rd));
    ext_en <= 88'hFF << 24;
    ext_val <= 88'hC3 << 24;
    wr(ra(PIO_DIR_BASE, 3), 32'h0);
    settle;
    rdr(ra(PIO_DATA_BASE, 3));
    chk("pin read", 88'hC3, 88'(rd));
    ext_en <= '0;
    wr(ra(PIO_DIR_BASE, 3), 32'hFF);
    settle;
    chk("latch kept", 88'h59, 88'(pin_out[31:24]));
    $display("test dir done");
  endtask

  task automatic t_nmi;
    for (int v = 0; v < 2; v++) begin
      ext_en <= 88'h1 << PIO_NMI_PIN;
      ext_val <= 88'(v) << PIO_NMI_PIN;
      settle;
      chk("nmi level", 88'(v), 88'(nmi_level));
      rdr(ra(PIO_DATA_BASE, 8));
      chk("nmi bit", 88'(v), 88'(rd[5]));
    end
    $display("test nmi done");
  endtask

  task automatic t_pull;
    wr(ra(PIO_DIR_BASE, 5), 32'h0F);
    wr(PIO_PULL_ADDR, 32'h3FFFFF);
    settle;
    chk("pull by dir", 88'hF0 << 40, pin_pullup);
    wr(ra(PIO_DIR_BASE, 8), 32'h0);
    wr(PIO_PULL_ADDR, 32'h1 << 17);
    settle;
    chk("pull group", 88'hD << 68, pin_pullup);
    wr(ra(PIO_DIR_BASE, 8), 32'hFF);
    $display("test pull done");
  endtask

  task automatic t_sel;
    wr(ra(PIO_SELA_BASE, 0), 32'hFF);
    for (int i = 0; i < 4; i++) begin
      wr(ra(PIO_SELB_BASE, 0), (i == 1) ? 32'hFF : 32'h0);
      wr(ra(PIO_SELC_BASE, 0), (i == 2) ? 32'hFF : 32'h0);
      wr(ra(PIO_SELD_BASE, 0), (i == 3) ? 32'hFF : 32'h0);
      settle;
      chk("periph out", 88'(8'h11 << i), 88'(pin_out[7:0]));
    end
    wr(ra(PIO_SELA_BASE, 0), 32'h0);
    settle;
    chk("port out", 88'h5A, 88'(pin_out[7:0]));
    $display("test select done");
  endtask

  task automatic t_bus;
    wr(ra(PIO_DIR_BASE, 0), 32'h0);
    wr(ra(PIO_DATA_BASE, 1), 32'h0);
    wr(PIO_PULL_ADDR, 32'h3FFFF3);
    bus_mode <= 1'b1;
    bus_pin_mask <= 88'hFF << 8;
    bus_out <= 88'h96 << 8;
    bus_oe <= 88'hF0 << 8;
    settle;
    chk("bus drive", 88'h90, 88'(pin_out[15:8] & 8'hF0));
    chk("bus oe_n", 88'h0F, 88'(pin_oe_n[15:8]));
    chk("port0 pull", 88'hFF, 88'(pin_pullup[7:0]));
    bus_mode <= 1'b0;
    settle;
    chk("port back", 88'h0, 88'(pin_out[15:8]));
    $display("test bus done");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_dir;
    t_nmi;
    t_pull;
    t_sel;
    t_bus;
    end_of_test;
  end
endmodule // programmable_io_port_block_bench
